/* hw/rtct_timers.sv */
// Countdown timer and second/minute tick timers with their flags and interrupt.
// Assumes register accesses arrive as one-cycle strobes from the serial front end.
`timescale 1ns/1ps
// Behaviour
// - Source select picks 4096, 64, 1, 1/60 Hz
// - Run enable bit gates countdown
// - Binary down count from loaded 8-bit value
// - Loaded zero stops the countdown
// - At one set flag and auto reload
// - Count read returns live counter
// - New count written takes effect immediately
// - First period after enable may vary
// - Countdown flag sticky until software clears
// - Interrupt pulse or level, enable gates it
// - Minute and second tick enables are independent
// - Tick flag follows second, else minute increment
// - Tick flag readable and clearable by host
// - Tick pulses regardless of tick flag state
// - Offset correction stretches slow periods; corr_hold here also stretches the 4096 Hz periods
// - Control at 0Eh, count at 0Fh
// - Flag writes AND into flags
// - Countdown pulse width depends on source, count
// - Tick pulse lasts one 64 Hz period
module rtct_timers import rtct_pkg::*; (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Register port
	input  wire logic [4:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Offset correction request
	input  wire logic       corr_hold,
	// Open-drain interrupt pin
	output logic            irq_out,
	output logic            irq_oe,
	// Clock-out frequency select for the square-wave block
	output logic      [2:0] square_wave_freq_select
);

	logic               en_8192;
	logic               en_4096;
	logic               en_128;
	logic               en_64;
	logic               en_1hz;

	logic               minute_tick_enable_reg;
	logic               second_tick_enable_reg;
	logic               tick_flag_reg;
	logic               irq_pulse_mode_select_reg;
	logic               countdown_done_flag_reg;
	logic               countdown_irq_enable_reg;
	logic               countdown_run_enable_reg;
	rtct_src_t          countdown_source_select_reg;
	logic [2:0]         sqw_sel_reg;
	logic [7:0]         reload_reg;
	logic [7:0]         cnt_reg;
	logic [5:0]         sec_cnt_reg;
	logic               tick_pulse_reg;
	rtct_cpulse_t       cd_pulse_reg;
	rtct_cpulse_t       cd_pulse_next;
	logic               cd_armed_reg;
	logic [7:0]         rdata_reg;
	logic               irq_oe_reg;

	logic               wr_ctrl2;
	logic               wr_tmr_ctrl;
	logic               wr_cnt;
	logic               min_tick;
	logic               src_tick;
	logic               cd_active;
	logic               cd_end;
	logic               tick_evt;
	logic               tf_clear;
	logic               tick_clear;
	logic               cd_pulse_stop;
	logic               cd_irq;
	logic               tick_irq;

	rtct_prescaler u_prescaler (
		.clk       (clk),
		.srst      (srst),
		.corr_hold (corr_hold),
		.en_8192   (en_8192),
		.en_4096   (en_4096),
		.en_128    (en_128),
		.en_64     (en_64),
		.en_1hz    (en_1hz)
	);

	always_comb begin
		wr_ctrl2    = 1'b0;
		wr_tmr_ctrl = 1'b0;
		wr_cnt      = 1'b0;
		if (reg_wr && reg_addr == ADDR_CTRL2) begin
			wr_ctrl2 = 1'b1;
		end else if (reg_wr && reg_addr == ADDR_TMR_CTRL) begin
			wr_tmr_ctrl = 1'b1;
		end else if (reg_wr && reg_addr == ADDR_CNT) begin
			wr_cnt = 1'b1;
		end
	end

	// Seconds counter; its wrap is the minute increment
	always_ff @(posedge clk) begin
		if (srst) begin
			sec_cnt_reg <= '0;
		end else if (en_1hz) begin
			sec_cnt_reg <= (sec_cnt_reg == SEC_LAST) ? 6'h00 : sec_cnt_reg + 6'h01;
		end
	end

	assign min_tick = en_1hz && sec_cnt_reg == SEC_LAST;

	always_comb begin
		case (countdown_source_select_reg)
			SRC_4096: src_tick = en_4096;
			SRC_64:   src_tick = en_64;
			SRC_1HZ:  src_tick = en_1hz;
			default:  src_tick = min_tick;
		endcase
	end

	assign cd_active = countdown_run_enable_reg && reload_reg != 8'h00;
	// period end at count one; a stray zero left by a mid-period write also ends it
	assign cd_end    = cd_active && cd_armed_reg && src_tick && cnt_reg <= 8'h01;

	// first source tick only arms for the 4096 and 64 Hz sources
	// Slow sources arm on the 64 Hz grid, which gives their 1/64 s lead
	always_ff @(posedge clk) begin
		if (srst || !cd_active) begin
			cd_armed_reg <= 1'b0;
		end else if (countdown_source_select_reg inside {SRC_1HZ, SRC_MIN} ?
				en_64 : src_tick) begin
			cd_armed_reg <= 1'b1;
		end
	end

	// Control registers
	always_ff @(posedge clk) begin
		if (srst) begin
			minute_tick_enable_reg    <= CTRL2_RST[C2_MIN_EN];
			second_tick_enable_reg    <= CTRL2_RST[C2_SEC_EN];
			irq_pulse_mode_select_reg <= CTRL2_RST[C2_PULSE];
			countdown_irq_enable_reg  <= CTRL2_RST[C2_CD_IRQ_EN];
		end else if (wr_ctrl2) begin
			minute_tick_enable_reg    <= reg_wdata[C2_MIN_EN];
			second_tick_enable_reg    <= reg_wdata[C2_SEC_EN];
			irq_pulse_mode_select_reg <= reg_wdata[C2_PULSE];
			countdown_irq_enable_reg  <= reg_wdata[C2_CD_IRQ_EN];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sqw_sel_reg                 <= TMR_CTRL_RST[TC_SQW_LSB +: 3];
			countdown_run_enable_reg    <= TMR_CTRL_RST[TC_RUN_EN];
			countdown_source_select_reg <= rtct_src_t'(TMR_CTRL_RST[TC_SRC_LSB +: 2]);
		end else if (wr_tmr_ctrl) begin
			sqw_sel_reg                 <= reg_wdata[TC_SQW_LSB +: 3];
			countdown_run_enable_reg    <= reg_wdata[TC_RUN_EN];
			countdown_source_select_reg <= rtct_src_t'(reg_wdata[TC_SRC_LSB +: 2]);
		end
	end

	// free-running prescaler gives the uncertain first period
	always_ff @(posedge clk) begin
		if (srst) begin
			reload_reg <= CNT_RST;
			cnt_reg    <= CNT_RST;
		end else if (wr_cnt) begin
			reload_reg <= reg_wdata;
			cnt_reg    <= reg_wdata;
		end else if (cd_end) begin
			cnt_reg <= reload_reg;
		end else if (cd_active && cd_armed_reg && src_tick) begin
			cnt_reg <= cnt_reg - 8'h01;
		end
	end

	// writing zero clears, writing one keeps
	assign tf_clear   = wr_ctrl2 && !reg_wdata[C2_CD_FLAG];
	assign tick_clear = wr_ctrl2 && !reg_wdata[C2_TICK_FLAG];

	// sticky countdown flag; a period end beats a clear
	always_ff @(posedge clk) begin
		if (srst) begin
			countdown_done_flag_reg <= CTRL2_RST[C2_CD_FLAG];
		end else begin
			countdown_done_flag_reg <= (countdown_done_flag_reg && !tf_clear) || cd_end;
		end
	end

	assign tick_evt = second_tick_enable_reg ? en_1hz :
		(minute_tick_enable_reg && min_tick);

	always_ff @(posedge clk) begin
		if (srst) begin
			tick_flag_reg <= CTRL2_RST[C2_TICK_FLAG];
		end else begin
			tick_flag_reg <= (tick_flag_reg && !tick_clear) || tick_evt;
		end
	end

	// one 64 Hz period, cut short by a flag clear
	always_ff @(posedge clk) begin
		if (srst) begin
			tick_pulse_reg <= 1'b0;
		end else if (tick_evt) begin
			tick_pulse_reg <= 1'b1;
		end else if (en_64 || tick_clear) begin
			tick_pulse_reg <= 1'b0;
		end
	end

	// pulse end picked by source and count
	always_comb begin
		case (countdown_source_select_reg)
			SRC_4096: cd_pulse_stop = (reload_reg == 8'h01) ? en_8192 : en_4096;
			SRC_64:   cd_pulse_stop = (reload_reg == 8'h01) ? en_128 : en_64;
			default:  cd_pulse_stop = en_64;
		endcase
	end

	always_comb begin
		cd_pulse_next = cd_pulse_reg;
		case (cd_pulse_reg)
			CP_IDLE: begin
				if (cd_end) begin
					cd_pulse_next = CP_ACTIVE;
				end
			end
			default: begin
				if (cd_end) begin
					cd_pulse_next = CP_ACTIVE;
				end else if (cd_pulse_stop || tf_clear) begin
					cd_pulse_next = CP_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cd_pulse_reg <= CP_IDLE;
		end else begin
			cd_pulse_reg <= cd_pulse_next;
		end
	end

	// pulse or level, gated by enable
	assign cd_irq   = countdown_irq_enable_reg && (irq_pulse_mode_select_reg ?
		cd_pulse_reg == CP_ACTIVE : countdown_done_flag_reg);
	assign tick_irq = (minute_tick_enable_reg || second_tick_enable_reg) &&
		(irq_pulse_mode_select_reg ? tick_pulse_reg : tick_flag_reg);

	// Pin only ever pulls low, so the output bit stays at zero
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_oe_reg <= 1'b0;
		end else begin
			irq_oe_reg <= cd_irq || tick_irq;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == ADDR_CTRL2) begin
				rdata_reg <= {minute_tick_enable_reg, second_tick_enable_reg,
					tick_flag_reg, irq_pulse_mode_select_reg, 1'b0,
					countdown_done_flag_reg, 1'b0, countdown_irq_enable_reg};
			end else if (reg_addr == ADDR_TMR_CTRL) begin
				rdata_reg <= {1'b0, sqw_sel_reg, countdown_run_enable_reg, 1'b0,
					countdown_source_select_reg};
			end else if (reg_addr == ADDR_CNT) begin
				rdata_reg <= cnt_reg;
			end else begin
				rdata_reg <= 8'h00;
			end
		end
	end

	assign reg_rdata               = rdata_reg;
	assign irq_out                 = 1'b0;
	assign irq_oe                  = irq_oe_reg;
	assign square_wave_freq_select = sqw_sel_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	chk_src_one_hz: assert property (
		countdown_source_select_reg == SRC_1HZ |-> src_tick == en_1hz)
		else $error("1 Hz source not selected");
	chk_run_gate_hold: assert property (
		!countdown_run_enable_reg && !wr_cnt |=> $stable(cnt_reg))
		else $error("counter moved while disabled");
	chk_count_step: assert property (
		cd_active && cd_armed_reg && src_tick && cnt_reg > 8'h01 && !wr_cnt
		|=> cnt_reg == $past(cnt_reg) - 8'h01)
		else $error("down count step wrong");
	chk_zero_stops: assert property (
		reload_reg == 8'h00 && !wr_cnt |=> $stable(cnt_reg) && !$rose(countdown_done_flag_reg))
		else $error("zero count did not stop timer");
	chk_end_reload: assert property (
		cd_end && !wr_cnt |=> cnt_reg == $past(reload_reg) && countdown_done_flag_reg)
		else $error("no reload or flag at period end");
	chk_read_live: assert property (
		reg_rd && reg_addr == ADDR_CNT |=> reg_rdata == $past(cnt_reg))
		else $error("count read not live");
	chk_write_now: assert property (
		wr_cnt |=> cnt_reg == $past(reg_wdata) && reload_reg == $past(reg_wdata))
		else $error("count write not immediate");
	chk_first_skip: assert property (
		cd_active && !cd_armed_reg && !wr_cnt |=> $stable(cnt_reg))
		else $error("counted before arming tick");
	chk_flag_sticky: assert property (
		countdown_done_flag_reg && !tf_clear |=> countdown_done_flag_reg)
		else $error("countdown flag lost");
	chk_irq_gated: assert property (
		!countdown_irq_enable_reg && !minute_tick_enable_reg && !second_tick_enable_reg
		|=> !irq_oe)
		else $error("interrupt with all sources disabled");
	chk_tick_none: assert property (
		!minute_tick_enable_reg && !second_tick_enable_reg && !tick_flag_reg
		|=> !tick_flag_reg)
		else $error("tick flag set with ticks disabled");
	chk_tick_pulse_set: assert property (
		tick_evt |=> tick_pulse_reg && tick_flag_reg)
		else $error("tick pulse missing");
	chk_flag_and_clear: assert property (
		tf_clear && !cd_end |=> !countdown_done_flag_reg)
		else $error("flag not cleared by zero write");
	chk_tick_pulse_end: assert property (
		tick_pulse_reg && en_64 && !tick_evt |=> !tick_pulse_reg)
		else $error("tick pulse too long");

	cov_cd_end:     cover property (cd_end && countdown_source_select_reg == SRC_4096);
	cov_tick_min:   cover property (tick_evt && !second_tick_enable_reg);
	cov_cd_pulse:   cover property (cd_pulse_reg == CP_ACTIVE ##1 cd_pulse_reg == CP_IDLE);
	cov_irq_rise:   cover property ($rose(irq_oe));

endmodule

/* inc/rtct_pkg.sv */
// Constants, types and helpers shared by the countdown and tick timer block.
// Assumes a single 20 MHz system clock with synchronous active-high reset.
package rtct_pkg;

	// System clock and the oscillator rate that the timers are built on
	localparam longint CLK_HZ       = 64'd20000000;
	localparam longint OSC_HZ       = 64'd32768;
	localparam int     PHASE_W      = 24;
	localparam logic [PHASE_W-1:0] PHASE_STEP =
		PHASE_W'((OSC_HZ << PHASE_W) / CLK_HZ);
	localparam int     PRE_W        = 15;

	// Prescaler masks: an enable fires when the masked low bits are all ones
	localparam logic [PRE_W-1:0] MASK_8192 = 15'h0003;
	localparam logic [PRE_W-1:0] MASK_4096 = 15'h0007;
	localparam logic [PRE_W-1:0] MASK_128  = 15'h00ff;
	localparam logic [PRE_W-1:0] MASK_64   = 15'h01ff;
	localparam logic [PRE_W-1:0] MASK_1HZ  = 15'h7fff;

	// Seconds per minute, as the last count of the seconds counter
	localparam logic [5:0] SEC_LAST = 6'h3b;

	// Register addresses
	localparam logic [4:0] ADDR_CTRL2    = 5'h01;
	localparam logic [4:0] ADDR_TMR_CTRL = 5'h0e;
	localparam logic [4:0] ADDR_CNT      = 5'h0f;

	// Control_2 field positions
	localparam int C2_MIN_EN    = 7;
	localparam int C2_SEC_EN    = 6;
	localparam int C2_TICK_FLAG = 5;
	localparam int C2_PULSE     = 4;
	localparam int C2_CD_FLAG   = 2;
	localparam int C2_CD_IRQ_EN = 0;

	// Timer and clock-out control field positions
	localparam int TC_SQW_LSB = 4;
	localparam int TC_RUN_EN  = 3;
	localparam int TC_SRC_LSB = 0;

	// Values after reset
	localparam logic [7:0] CTRL2_RST    = 8'h00;
	localparam logic [7:0] TMR_CTRL_RST = 8'h03;
	localparam logic [7:0] CNT_RST      = 8'h00;

	typedef enum logic [1:0] {
		SRC_4096 = 2'b00,
		SRC_64   = 2'b01,
		SRC_1HZ  = 2'b10,
		SRC_MIN  = 2'b11
	} rtct_src_t;

	typedef enum logic {
		CP_IDLE   = 1'b0,
		CP_ACTIVE = 1'b1
	} rtct_cpulse_t;

	function automatic logic rtct_low_ones(input logic [PRE_W-1:0] v,
		input logic [PRE_W-1:0] mask);
		return &(v | ~mask);
	endfunction

endpackage

/* hw/rtct_prescaler.sv */
// Oscillator-rate prescaler: makes one-cycle enables for the timer rates.
// Assumes clk is the 20 MHz system clock; corr_hold comes from offset logic.
`timescale 1ns/1ps
module rtct_prescaler import rtct_pkg::*; (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Offset correction
	input  wire logic corr_hold,
	// Rate enables
	output logic      en_8192,
	output logic      en_4096,
	output logic      en_128,
	output logic      en_64,
	output logic      en_1hz
);

	logic [PHASE_W:0]   phase_reg;
	logic [PHASE_W:0]   phase_next;
	logic [PRE_W-1:0]   pre_reg;
	logic               osc_tick;

	// Fractional divide: carry out of the accumulator is the oscillator tick
	assign phase_next = {1'b0, phase_reg[PHASE_W-1:0]} + {1'b0, PHASE_STEP};
	assign osc_tick   = phase_reg[PHASE_W];

	always_ff @(posedge clk) begin
		if (srst) begin
			phase_reg <= '0;
		end else begin
			phase_reg <= phase_next;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pre_reg <= '0;
		end else if (osc_tick && !corr_hold) begin
			pre_reg <= pre_reg + 15'h0001;
		end
	end

	assign en_8192 = osc_tick && !corr_hold && rtct_low_ones(pre_reg, MASK_8192);
	assign en_4096 = osc_tick && !corr_hold && rtct_low_ones(pre_reg, MASK_4096);
	assign en_128  = osc_tick && !corr_hold && rtct_low_ones(pre_reg, MASK_128);
	assign en_64   = osc_tick && !corr_hold && rtct_low_ones(pre_reg, MASK_64);
	assign en_1hz  = osc_tick && !corr_hold && rtct_low_ones(pre_reg, MASK_1HZ);

endmodule

/* verification/rtct_host_model.sv */
// Host model: register reads and writes on the strobe port of the timer block.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
module rtct_host_model import rtct_pkg::*; (
	// Clock
	input  wire logic       clk,
	// Register port
	output logic      [4:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr  = 5'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		// Released lines flip so that stale values are never trusted
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask

	task automatic rd_live(input logic [4:0] a, output logic [7:0] d);
		logic [7:0] first;
		logic [7:0] again;
		rd(a, first);
		again = ~first;
		for (int i = 0; i < 4 && again !== first; i++) begin
			if (i > 0) first = again;
			rd(a, again);
		end
		d = again;
	endtask
endmodule

/* verification/rtct_timers_test.sv */
// Self-checking bench for the countdown timer block, driven through the host model.
// Assumes the 20 MHz clock; only the 4096 Hz source is fast enough to time in a run.
`timescale 1ns/1ps
module rtct_timers_test import rtct_pkg::*; ;
	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
	} rtct_row_t;
	localparam int CYCLE_LIMIT = 95000;
	localparam rtct_row_t ROWS [8] = '{
		'{ADDR_TMR_CTRL, 8'h0a, 8'h0a}, '{ADDR_TMR_CTRL, 8'h21, 8'h21},
		'{ADDR_TMR_CTRL, 8'hff, 8'h7b}, '{ADDR_TMR_CTRL, 8'h73, 8'h73},
		'{ADDR_CTRL2, 8'hff, 8'hd1}, '{ADDR_CTRL2, 8'h00, 8'h00},
		'{5'h05, 8'haa, 8'h00}, '{ADDR_CNT, 8'h00, 8'h00}};

	logic       clk;
	logic       srst;
	logic       corr_hold;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       irq_out;
	logic       irq_oe;
	logic [2:0] square_wave_freq_select;
	wire        int_pin_n;
	int         fails = 0;
	int         comparisons = 0;
	int         cycle = 0;

	// Pull-up on the open-drain interrupt line
	assign int_pin_n = irq_oe ? irq_out : 1'b1;

	rtct_timers dut (
		.clk                     (clk),
		.srst                    (srst),
		.reg_addr                (reg_addr),
		.reg_wdata               (reg_wdata),
		.reg_wr                  (reg_wr),
		.reg_rd                  (reg_rd),
		.reg_rdata               (reg_rdata),
		.corr_hold               (corr_hold),
		.irq_out                 (irq_out),
		.irq_oe                  (irq_oe),
		.square_wave_freq_select (square_wave_freq_select)
	);

	rtct_host_model host (
		.clk       (clk),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata)
	);

	initial clk = 1'b0;
	always #25 clk = ~clk;

	task automatic report_and_stop();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wait_change(input logic [7:0] prev, output logic [7:0] now);
		now = prev;
		for (int n = 0; n < 3000 && now === prev; n++) host.rd_live(ADDR_CNT, now);
	endtask

	// Length of the next low phase of the interrupt line, in clock cycles
	task automatic measure_low(output int w);
		for (int n = 0; n < 6000 && int_pin_n !== 1'b1; n++) @(posedge clk);
		for (int n = 0; n < 25000 && int_pin_n !== 1'b0; n++) @(posedge clk);
		for (w = 0; w < 6000 && int_pin_n === 1'b0; w++) @(posedge clk);
	endtask

	always @(posedge clk) begin
		cycle++;
		if (cycle >= CYCLE_LIMIT) begin
			fails++;
			report_and_stop();
		end
	end

	initial begin
		logic [7:0] v;
		logic [7:0] v0;
		int         t0;
		int         w;
		srst      = 1'b1;
		corr_hold = 1'b0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		foreach (ROWS[i]) begin
			host.wr(ROWS[i].addr, ROWS[i].wdata);
			host.rd(ROWS[i].addr, v);
			check(16'(v), 16'(ROWS[i].rdata), "register row"); // map and flag writes
		end
		check(16'(square_wave_freq_select), 16'h7, "clock-out field"); // field position
		$display("test register rows done");
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		host.rd(ADDR_TMR_CTRL, v);
		check(16'(v), 16'(TMR_CTRL_RST), "reset ctrl"); // power-saving source
		host.rd(ADDR_CNT, v);
		check(16'(v), 16'(CNT_RST), "reset count"); // stopped after reset
		host.rd(ADDR_CTRL2, v);
		check(16'(v), 16'(CTRL2_RST), "reset flags"); // flags start clear
		check(16'({int_pin_n, square_wave_freq_select}), 16'h8, "reset pins"); // idle pin
		$display("test reset done");
		host.wr(ADDR_CNT, 8'h03);
		host.wr(ADDR_TMR_CTRL, 8'h08);
		t0 = cycle;
		wait_change(8'h03, v);
		check(16'(v), 16'h2, "first step"); // binary down count
		check(16'(cycle - t0 >= 4880 && cycle - t0 <= 9790), 16'h1, "first period"); // bound
		t0 = cycle;
		wait_change(8'h02, v);
		w = cycle - t0;
		check(16'(v), 16'h1, "second step"); // live count read
		check(16'(w >= 4872 && w <= 4894), 16'h1, "4096 Hz step"); // source rate
		wait_change(8'h01, v);
		check(16'(v), 16'h3, "reload"); // automatic reload
		host.rd(ADDR_CTRL2, v);
		check(16'(v), 16'h04, "flag set"); // flag at period end
		check(16'(int_pin_n), 16'h1, "irq disabled"); // enable gates pin
		host.wr(ADDR_CTRL2, 8'h05);
		repeat (2) @(posedge clk);
		check(16'(int_pin_n), 16'h0, "level irq"); // level follows flag
		wait_change(8'h03, v);
		host.rd(ADDR_CTRL2, v);
		check(16'(v), 16'h05, "flag sticky"); // flag stays set
		host.wr(ADDR_CTRL2, 8'h01);
		host.rd(ADDR_CTRL2, v);
		check(16'({v, 7'h00, int_pin_n}), 16'h0101, "flag clear"); // AND clear
		$display("test countdown done");
		host.wr(ADDR_CNT, 8'h05);
		host.rd(ADDR_CNT, v);
		check(16'(v), 16'h5, "write while running"); // immediate effect
		@(posedge clk);
		corr_hold <= 1'b1;
		repeat (4) @(posedge clk);
		host.rd(ADDR_CNT, v0);
		repeat (5000) @(posedge clk);
		host.rd(ADDR_CNT, v);
		check(16'(v), 16'(v0), "held ticks"); // correction stretches periods
		@(posedge clk);
		corr_hold <= 1'b0;
		host.wr(ADDR_TMR_CTRL, 8'h00);
		host.rd(ADDR_CNT, v0);
		repeat (5000) @(posedge clk);
		host.rd(ADDR_CNT, v);
		check(16'(v), 16'(v0), "run off"); // run enable gates count
		host.wr(ADDR_CNT, 8'h00);
		host.wr(ADDR_CTRL2, 8'h00);
		host.wr(ADDR_TMR_CTRL, 8'h08);
		repeat (5000) @(posedge clk);
		host.rd(ADDR_CNT, v);
		host.rd(ADDR_CTRL2, v0);
		check(16'({v, v0}), 16'h0000, "zero count"); // zero stops timer
		$display("test stop cases done");
		for (int k = 0; k < 2; k++) begin
			host.wr(ADDR_TMR_CTRL, 8'h00);
			host.wr(ADDR_CNT, (k == 1) ? 8'h03 : 8'h01);
			host.wr(ADDR_CTRL2, 8'h11);
			host.wr(ADDR_TMR_CTRL, 8'h08);
			measure_low(w);
			w = w - ((k == 1) ? 4883 : 2441);
			check(16'(w >= -8 && w <= 8), 16'h1, "pulse width"); // width by count
		end
		$display("test pulse width done");
		report_and_stop();
	end
endmodule
